// *** logic/dps_pkg.sv ***
// dps_pkg: encodings and field positions for the programming front end
// assumes one 40 MHz system clock and a byte-wide host write port
package dps_pkg;

    // clock
    localparam int unsigned CLK_HZ = 40_000_000;

    // byte decoding
    localparam int unsigned TYPE_BIT      = 7;
    localparam int unsigned PTR_LSB       = 3;
    localparam int unsigned PTR_W         = 4;
    localparam int unsigned CTRL_W        = 3;
    localparam logic [1:0]  GRP_CODE_NONE = 2'h0;
    localparam logic [1:0]  GRP_CODE_CMD  = 2'h3;

    // command group bytes
    localparam logic [7:0] CMD_ENABLE      = 8'h87;
    localparam logic [7:0] CMD_DISABLE     = 8'h83;
    localparam logic [7:0] CMD_REARM       = 8'h8B;
    localparam logic [7:0] CMD_FORCE_READY = 8'hB3;

    // transfer modes
    localparam logic [1:0] MODE_BYTE  = 2'h0;
    localparam logic [1:0] MODE_BURST = 2'h1;
    localparam logic [1:0] MODE_CONT  = 2'h2;

    // state codes on state_o
    localparam logic [1:0] ST_CODE_DISABLED  = 2'h0;
    localparam logic [1:0] ST_CODE_STOPPED   = 2'h1;
    localparam logic [1:0] ST_CODE_SUSPENDED = 2'h2;
    localparam logic [1:0] ST_CODE_OPERATING = 2'h3;

    // reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    typedef enum logic [1:0] {
        DPS_DISABLED,
        DPS_STOPPED,
        DPS_SUSPENDED,
        DPS_OPERATING
    } dps_state_t;

endpackage

// *** logic/dps_group0_seq.sv ***
// dps_group0_seq: stores the associated bytes that follow a group-zero base byte
// assumes load_i and data_wr_i are one-cycle pulses, never both at once
module dps_group0_seq #(
    parameter int unsigned PTR_W = dps_pkg::PTR_W
) (
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    // control
    input  wire logic             load_i,
    input  wire logic [PTR_W-1:0] ptr_i,
    input  wire logic             data_wr_i,
    input  wire logic [7:0]       data_i,
    // state
    output logic                  busy_o,
    output logic [15:0]           port_a_addr_o,
    output logic [15:0]           block_len_o
);

    logic [PTR_W-1:0] pend_q;
    logic [PTR_W-1:0] pend_d;
    logic [7:0]       byte_q [PTR_W];
    logic [7:0]       byte_d [PTR_W];

    // one-hot of the lowest pending pointer
    function automatic logic [PTR_W-1:0] lowest_one(input logic [PTR_W-1:0] v);
        lowest_one = v & (~v + PTR_W'(1));
    endfunction

    always_comb begin
        logic [PTR_W-1:0] sel;
        sel    = lowest_one(pend_q);
        pend_d = pend_q;
        byte_d = byte_q;
        if (load_i) begin
            pend_d = ptr_i;
        end else if (data_wr_i && pend_q != '0) begin
            for (int i = 0; i < PTR_W; i++) begin
                if (sel[i]) begin
                    byte_d[i] = data_i;
                end
            end
            pend_d = pend_q & ~sel;
        end
    end

    generate
        for (genvar g = 0; g < PTR_W; g++) begin : g_byte
            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    byte_q[g] <= dps_pkg::RST_BYTE;
                end else begin
                    byte_q[g] <= byte_d[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_d;
        end
    end

    assign busy_o        = (pend_q != '0);
    assign port_a_addr_o = {byte_q[1], byte_q[0]};
    assign block_len_o   = {byte_q[3], byte_q[2]};

    a_seq_order: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (data_wr_i && !load_i && pend_q[0]) |=> (byte_q[0] == $past(data_i)) && !pend_q[0])
        else $error("pointed byte not stored in order");

endmodule

// *** logic/dps_program_state_control.sv ***
// dps_program_state_control: host programming port and enable/disable state control
// assumes host strobes are synchronous one-cycle pulses and chip select is decoded outside
// Behaviour
// - reset places the controller disabled, bus request high, no transfers.
// - any byte written while stopped disables until the enable command.
// - every command except enable disables; a lone status rearm does not.
// - while disabled the bus request output stays high.
// - end of block stops and releases the bus unless auto restart.
// - byte match stops and releases the bus.
// - byte or burst mode with daisy acknowledge inactive stops.
// - enable with ready inactive and no force leaves controller stopped.
// - enable outside service routine with ready or force starts operating.
// - all bytes pass through one port qualified only by chip select.
// - host writes are ignored while the controller is bus master.
// - a base byte selects a group and points at following registers.
// - following bytes fill pointed registers in fixed order, skipping others.
// - group-zero base is bit 7 low and low bits not both zero.
module dps_program_state_control (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // host port
    input  wire logic        chip_sel_n_i,
    input  wire logic        wr_strobe_i,
    input  wire logic        rd_strobe_i,
    input  wire logic [7:0]  wr_data_i,
    output logic      [7:0]  rd_data_o,
    // configuration
    input  wire logic [1:0]  xfer_mode_i,
    input  wire logic        auto_restart_i,
    // system events
    input  wire logic        ready_i,
    input  wire logic        bus_ack_daisy_in_i,
    input  wire logic        end_of_block_i,
    input  wire logic        byte_match_i,
    input  wire logic        return_from_interrupt_opcode_i,
    input  wire logic        in_service_i,
    // status and programmed values
    output logic             bus_request_out_n_o,
    output logic             xfer_run_o,
    output logic      [1:0]  state_o,
    output logic      [2:0]  setup_ctrl_o,
    output logic      [15:0] port_a_addr_o,
    output logic      [15:0] block_len_o
);

    dps_pkg::dps_state_t state_q;
    dps_pkg::dps_state_t state_d;
    logic                force_q;
    logic                force_d;
    logic                last_cmd_q;
    logic                last_cmd_d;
    logic [2:0]          ctrl_q;
    logic [2:0]          ctrl_d;
    logic [7:0]          rd_q;
    logic [7:0]          rd_d;

    logic                master;
    logic                wr_ok;
    logic                seq_busy;
    logic                is_cmd;
    logic                is_g0;
    logic                ready_eff;
    logic                enable_cmd;
    logic                keeps_state;

    function automatic logic is_cmd_grp(input logic [7:0] b);
        is_cmd_grp = b[dps_pkg::TYPE_BIT] && (b[1:0] == dps_pkg::GRP_CODE_CMD);
    endfunction

    function automatic logic is_g0_base(input logic [7:0] b);
        is_g0_base = !b[dps_pkg::TYPE_BIT] && (b[1:0] != dps_pkg::GRP_CODE_NONE);
    endfunction

    function automatic logic [1:0] state_code(input dps_pkg::dps_state_t s);
        case (s)
            dps_pkg::DPS_STOPPED:   state_code = dps_pkg::ST_CODE_STOPPED;
            dps_pkg::DPS_SUSPENDED: state_code = dps_pkg::ST_CODE_SUSPENDED;
            dps_pkg::DPS_OPERATING: state_code = dps_pkg::ST_CODE_OPERATING;
            default:                state_code = dps_pkg::ST_CODE_DISABLED;
        endcase
    endfunction

    assign master     = (state_q == dps_pkg::DPS_OPERATING) ||
                        (state_q == dps_pkg::DPS_SUSPENDED);
    assign wr_ok      = wr_strobe_i && !chip_sel_n_i && !master;
    assign is_cmd     = wr_ok && !seq_busy && is_cmd_grp(wr_data_i);
    assign is_g0      = wr_ok && !seq_busy && is_g0_base(wr_data_i);
    assign ready_eff  = ready_i || force_q;
    assign enable_cmd = is_cmd && (wr_data_i == dps_pkg::CMD_ENABLE);
    // a rearm with no command before it leaves the state alone
    assign keeps_state = is_cmd && (wr_data_i == dps_pkg::CMD_REARM) && !last_cmd_q;

    dps_group0_seq #(
        .PTR_W (dps_pkg::PTR_W)
    ) u_seq (
        .sys_clk_i     (sys_clk_i),
        .rst_i         (rst_i),
        .load_i        (is_g0),
        .ptr_i         (wr_data_i[dps_pkg::PTR_LSB +: dps_pkg::PTR_W]),
        .data_wr_i     (wr_ok && seq_busy),
        .data_i        (wr_data_i),
        .busy_o        (seq_busy),
        .port_a_addr_o (port_a_addr_o),
        .block_len_o   (block_len_o)
    );

    always_comb begin
        state_d    = state_q;
        force_d    = force_q;
        last_cmd_d = last_cmd_q;
        ctrl_d     = ctrl_q;
        rd_d       = rd_q;
        if (wr_ok) begin
            last_cmd_d = is_cmd;
        end
        if (is_g0) begin
            ctrl_d = wr_data_i[dps_pkg::CTRL_W-1:0];
        end
        if (is_cmd && wr_data_i == dps_pkg::CMD_FORCE_READY) begin
            force_d = 1'b1;
        end else if (is_cmd && wr_data_i == dps_pkg::CMD_DISABLE) begin
            force_d = 1'b0;
        end
        if (rd_strobe_i && !chip_sel_n_i) begin
            rd_d = {4'h0, ready_i, force_q, state_code(state_q)};
        end
        case (state_q)
            dps_pkg::DPS_DISABLED: begin
                if (enable_cmd) begin
                    if (ready_eff && !in_service_i) begin
                        state_d = dps_pkg::DPS_OPERATING;
                    end else begin
                        state_d = dps_pkg::DPS_STOPPED;
                    end
                end
            end
            dps_pkg::DPS_STOPPED: begin
                if (enable_cmd) begin
                    if (ready_eff && !in_service_i) begin
                        state_d = dps_pkg::DPS_OPERATING;
                    end
                end else if (wr_ok && !keeps_state) begin
                    state_d = dps_pkg::DPS_DISABLED;
                end else if (ready_eff && return_from_interrupt_opcode_i) begin
                    state_d = dps_pkg::DPS_OPERATING;
                end else if (ready_eff && xfer_mode_i == dps_pkg::MODE_BURST) begin
                    state_d = dps_pkg::DPS_OPERATING;
                end
            end
            dps_pkg::DPS_OPERATING, dps_pkg::DPS_SUSPENDED: begin
                if (end_of_block_i && !auto_restart_i) begin
                    state_d = dps_pkg::DPS_STOPPED;
                end else if (byte_match_i) begin
                    state_d = dps_pkg::DPS_STOPPED;
                end else if (xfer_mode_i != dps_pkg::MODE_CONT) begin
                    if (!bus_ack_daisy_in_i) begin
                        state_d = dps_pkg::DPS_STOPPED;
                    end else begin
                        state_d = dps_pkg::DPS_OPERATING;
                    end
                end else if (!ready_eff) begin
                    state_d = dps_pkg::DPS_SUSPENDED;
                end else begin
                    state_d = dps_pkg::DPS_OPERATING;
                end
            end
            default: begin
                state_d = dps_pkg::DPS_DISABLED;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q    <= dps_pkg::DPS_DISABLED;
            force_q    <= 1'b0;
            last_cmd_q <= 1'b0;
            ctrl_q     <= '0;
            rd_q       <= dps_pkg::RST_BYTE;
        end else begin
            state_q    <= state_d;
            force_q    <= force_d;
            last_cmd_q <= last_cmd_d;
            ctrl_q     <= ctrl_d;
            rd_q       <= rd_d;
        end
    end

    // bus request only while bus master
    assign bus_request_out_n_o = !master;
    assign xfer_run_o          = (state_q == dps_pkg::DPS_OPERATING);
    assign state_o             = state_code(state_q);
    assign setup_ctrl_o        = ctrl_q;
    assign rd_data_o           = rd_q;

    a_reset_disabled: assert property (@(posedge sys_clk_i)
        $fell(rst_i) |-> bus_request_out_n_o && !xfer_run_o && state_o == 2'h0)
        else $error("not disabled after reset");

    a_disabled_no_request: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_o == 2'h0) |-> bus_request_out_n_o && !xfer_run_o)
        else $error("bus requested while disabled");

    a_write_disables: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_q == dps_pkg::DPS_STOPPED && wr_ok && !is_cmd) |=> state_o == 2'h0)
        else $error("write while enabled did not disable");

    a_cmd_disables: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (is_cmd && wr_data_i != dps_pkg::CMD_ENABLE && wr_data_i != dps_pkg::CMD_REARM)
        |=> state_o == 2'h0 && bus_request_out_n_o)
        else $error("command did not leave controller disabled");

    a_eob_stops: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (master && end_of_block_i && !auto_restart_i) |=> state_o == 2'h1 && bus_request_out_n_o)
        else $error("end of block did not stop");

    a_match_stops: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (master && byte_match_i) |=> state_o == 2'h1 && bus_request_out_n_o)
        else $error("byte match did not stop");

    a_daisy_stops: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (master && xfer_mode_i != dps_pkg::MODE_CONT && !bus_ack_daisy_in_i) |=> state_o == 2'h1)
        else $error("inactive daisy acknowledge did not stop");

    a_enable_waits: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_q == dps_pkg::DPS_DISABLED && enable_cmd && !ready_eff)
        |=> state_o == 2'h1 && bus_request_out_n_o)
        else $error("enable without ready requested bus");

    a_enable_runs: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (enable_cmd && ready_eff && !in_service_i) |=> xfer_run_o && !bus_request_out_n_o)
        else $error("enable with ready did not start");

    a_return_runs: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_q == dps_pkg::DPS_STOPPED && !wr_ok && ready_eff && return_from_interrupt_opcode_i)
        |=> xfer_run_o)
        else $error("return fetch did not start transfers");

    a_master_ignores: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (master && wr_strobe_i) |=> $stable(setup_ctrl_o) && $stable(port_a_addr_o))
        else $error("write accepted while bus master");

    a_cont_pause: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (master && xfer_mode_i == dps_pkg::MODE_CONT && !ready_eff && !end_of_block_i &&
         !byte_match_i) |=> state_o == 2'h2 && !bus_request_out_n_o)
        else $error("continuous mode did not pause holding bus");

    a_g0_decode: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_ok && !seq_busy && !wr_data_i[7] && wr_data_i[1:0] != 2'h0)
        |=> setup_ctrl_o == $past(wr_data_i[2:0]))
        else $error("group-zero base byte not decoded");

endmodule

// *** dv/dps_host_model.sv ***
// dps_host_model: host processor, byte writes and status reads through one i/o port
// assumes one calling process in the bench and the bench clock
module dps_host_model #(
    parameter logic [7:0] PORT_ADDR = 8'h5A  // arbitrary port address
) (
    // clock
    input  wire logic       sys_clk_i,
    // controller bus state
    input  wire logic       bus_request_out_n_i,
    // host port
    output logic            chip_sel_n_o,
    output logic            wr_strobe_o,
    output logic            rd_strobe_o,
    output logic [7:0]      wr_data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic rude;  // scenario may write while the controller holds the bus

    initial begin
        chip_sel_n_o = 1'b1;
        wr_strobe_o  = 1'b0;
        rd_strobe_o  = 1'b0;
        wr_data_o    = 8'h00;
        rude         = 1'b0;
    end

    // only the low address byte selects the controller
    function automatic logic sel_n(input logic [15:0] addr);
        return addr[7:0] != PORT_ADDR;
    endfunction

    task automatic io_wr(input logic [15:0] addr, input logic [7:0] data);
        // bus state judged on a settled edge, not in the edge that changes it
        @(posedge sys_clk_i);
        if (!bus_request_out_n_i && !rude) begin
            return;
        end
        chip_sel_n_o <= sel_n(addr);
        wr_strobe_o  <= 1'b1;
        wr_data_o    <= data;
        @(posedge sys_clk_i);
        chip_sel_n_o <= 1'b1;
        wr_strobe_o  <= 1'b0;
        wr_data_o    <= ~data;  // released bus does not keep the byte
    endtask

    task automatic io_rd(input logic [15:0] addr);
        @(posedge sys_clk_i);
        if (!bus_request_out_n_i) begin
            return;
        end
        chip_sel_n_o <= sel_n(addr);
        rd_strobe_o  <= 1'b1;
        @(posedge sys_clk_i);
        chip_sel_n_o <= 1'b1;
        rd_strobe_o  <= 1'b0;
    endtask
endmodule

// *** dv/tb.sv ***
// tb: self-checking bench for the programming front end and state control
// assumes the host model in dps_host_model and the design under logic/
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] PORT = 16'h305A;
    logic        sys_clk_i, rst_i, cs_n, wr, rd, ready_i, daisy, eob, bmatch, rfi, in_svc, auto_r;
    logic [7:0]  wdat, rd_data_o;
    logic [1:0]  mode, state_o;
    logic        brq_n, run;
    logic [2:0]  sc_o, e_sc;
    logic [15:0] addr_o, len_o, e_addr, e_len;
    logic        e_frc, probe, rd_seen;
    logic [38:0] q_snap[$];
    logic [7:0]  q_stat[$];
    int          mismatches, n_compared;

    dps_host_model i_dps_host_model (.sys_clk_i(sys_clk_i), .bus_request_out_n_i(brq_n),
        .chip_sel_n_o(cs_n), .wr_strobe_o(wr), .rd_strobe_o(rd), .wr_data_o(wdat));

    dps_program_state_control i_dps_program_state_control (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .chip_sel_n_i(cs_n), .wr_strobe_i(wr), .rd_strobe_i(rd), .wr_data_i(wdat),
        .rd_data_o(rd_data_o), .xfer_mode_i(mode), .auto_restart_i(auto_r), .ready_i(ready_i),
        .bus_ack_daisy_in_i(daisy), .end_of_block_i(eob), .byte_match_i(bmatch),
        .return_from_interrupt_opcode_i(rfi), .in_service_i(in_svc),
        .bus_request_out_n_o(brq_n), .xfer_run_o(run), .state_o(state_o),
        .setup_ctrl_o(sc_o), .port_a_addr_o(addr_o), .block_len_o(len_o));

    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cmp_snap(input logic [38:0] seen);
        logic [38:0] exp;
        exp = q_snap.pop_front();
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH snapshot expected %h seen %h", exp, seen);
        end
    endtask

    task automatic cmp_stat(input logic [7:0] seen);
        logic [7:0] exp;
        exp = q_stat.pop_front();
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH status expected %h seen %h", exp, seen);
        end
    endtask

    // note expected outputs, then flag the cycle in which they are looked at
    task automatic snap(input logic [1:0] st);
        q_snap.push_back({st != dps_pkg::ST_CODE_OPERATING && st != dps_pkg::ST_CODE_SUSPENDED,
                          st == dps_pkg::ST_CODE_OPERATING, st, e_sc, e_addr, e_len});
        @(posedge sys_clk_i);
        probe <= 1'b1;
        @(posedge sys_clk_i);
        probe <= 1'b0;
    endtask

    task automatic status;
        q_stat.push_back({4'h0, ready_i, e_frc, dps_pkg::ST_CODE_DISABLED});
        i_dps_host_model.io_rd(PORT);
    endtask

    task automatic pulse(input int unsigned which);
        @(posedge sys_clk_i);
        case (which)
            0: eob <= 1'b1;
            1: bmatch <= 1'b1;
            default: rfi <= 1'b1;
        endcase
        @(posedge sys_clk_i);
        eob    <= 1'b0;
        bmatch <= 1'b0;
        rfi    <= 1'b0;
    endtask

    always @(posedge sys_clk_i) begin
        if (probe) begin
            cmp_snap({brq_n, run, state_o, sc_o, addr_o, len_o});
        end
        if (rd_seen) begin
            cmp_stat(rd_data_o);
        end
        rd_seen <= rd & !cs_n;
    end

    initial begin
        #(4000 * 25);
        mismatches++;
        $display("MISMATCH watchdog expected done seen timeout");
        report_and_stop();
    end

    initial begin
        logic [7:0] b;
        logic [7:0] d;
        logic [7:0] cmds [4];
        rst_i = 1'b1; ready_i = 1'b1; daisy = 1'b1; eob = 1'b0; bmatch = 1'b0; rfi = 1'b0;
        in_svc = 1'b0; auto_r = 1'b0; mode = dps_pkg::MODE_CONT; probe = 1'b0; rd_seen = 1'b0;
        e_sc = 3'h0; e_addr = 16'h0000; e_len = 16'h0000; e_frc = 1'b0;
        mismatches = 0; n_compared = 0;
        cmds = '{dps_pkg::CMD_DISABLE, dps_pkg::CMD_REARM, 8'h01, dps_pkg::CMD_FORCE_READY};
        void'($urandom(49987));
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        snap(dps_pkg::ST_CODE_DISABLED);
        status();
        $display("test reset done");
        for (int n = 0; n < 4; n++) begin
            b = 8'($urandom);
            b[7] = 1'b0;
            b[0] = b[0] | ~b[1];
            if (n == 0) b[6:3] = 4'hF;
            i_dps_host_model.io_wr(PORT, b);
            e_sc = b[2:0];
            for (int k = 0; k < 4; k++) begin
                if (b[3+k]) begin
                    d = 8'($urandom + k);
                    i_dps_host_model.io_wr(PORT, d);
                    if (k < 2) e_addr[8*k +: 8] = d;
                    else e_len[8*(k-2) +: 8] = d;
                end
            end
            snap(dps_pkg::ST_CODE_DISABLED);
        end
        i_dps_host_model.io_wr(PORT, 8'h04);
        i_dps_host_model.io_wr(16'h5A00, 8'h1E);
        snap(dps_pkg::ST_CODE_DISABLED);
        $display("test programming done");
        @(posedge sys_clk_i);
        ready_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            i_dps_host_model.io_wr(PORT, dps_pkg::CMD_ENABLE);
            snap(dps_pkg::ST_CODE_STOPPED);
            i_dps_host_model.io_wr(PORT, cmds[i]);
            if (i == 2) e_sc = 3'h1;
            if (i == 3) e_frc = 1'b1;
            snap(dps_pkg::ST_CODE_DISABLED);
        end
        status();
        i_dps_host_model.io_wr(PORT, dps_pkg::CMD_ENABLE);
        snap(dps_pkg::ST_CODE_OPERATING);
        pulse(0);
        snap(dps_pkg::ST_CODE_STOPPED);
        i_dps_host_model.io_wr(PORT, dps_pkg::CMD_DISABLE);
        e_frc = 1'b0;
        status();
        $display("test commands done");
        @(posedge sys_clk_i);
        ready_i <= 1'b1;
        i_dps_host_model.io_wr(PORT, dps_pkg::CMD_ENABLE);
        snap(dps_pkg::ST_CODE_OPERATING);
        i_dps_host_model.rude = 1'b1;
        i_dps_host_model.io_wr(PORT, dps_pkg::CMD_DISABLE);
        i_dps_host_model.rude = 1'b0;
        snap(dps_pkg::ST_CODE_OPERATING);
        @(posedge sys_clk_i);
        ready_i <= 1'b0;
        snap(dps_pkg::ST_CODE_SUSPENDED);
        @(posedge sys_clk_i);
        ready_i <= 1'b1;
        auto_r  <= 1'b1;
        snap(dps_pkg::ST_CODE_OPERATING);
        pulse(0);
        snap(dps_pkg::ST_CODE_OPERATING);
        @(posedge sys_clk_i);
        auto_r <= 1'b0;
        pulse(1);
        snap(dps_pkg::ST_CODE_STOPPED);
        pulse(2);
        snap(dps_pkg::ST_CODE_OPERATING);
        @(posedge sys_clk_i);
        mode  <= dps_pkg::MODE_BYTE;
        daisy <= 1'b0;
        snap(dps_pkg::ST_CODE_STOPPED);
        @(posedge sys_clk_i);
        daisy <= 1'b1;
        in_svc <= 1'b1;
        i_dps_host_model.io_wr(PORT, dps_pkg::CMD_DISABLE);
        i_dps_host_model.io_wr(PORT, dps_pkg::CMD_ENABLE);
        snap(dps_pkg::ST_CODE_STOPPED);
        pulse(2);
        snap(dps_pkg::ST_CODE_OPERATING);
        pulse(1);
        i_dps_host_model.io_wr(PORT, dps_pkg::CMD_DISABLE);
        snap(dps_pkg::ST_CODE_DISABLED);
        @(posedge sys_clk_i);
        in_svc  <= 1'b0;
        mode    <= dps_pkg::MODE_BURST;
        ready_i <= 1'b0;
        i_dps_host_model.io_wr(PORT, dps_pkg::CMD_ENABLE);
        snap(dps_pkg::ST_CODE_STOPPED);
        @(posedge sys_clk_i);
        ready_i <= 1'b1;
        snap(dps_pkg::ST_CODE_OPERATING);
        $display("test events done");
        repeat (3) @(posedge sys_clk_i);
        report_and_stop();
    end
endmodule
